/* src/rpdr_top.sv */
// Purpose: Serial register pair for recovery, pulse gating and supply, thermal and open-load diagnosis
// Assumes: Serial clock far slower than i_mclk; pins synchronised here
// Notes:   Register pair zero is held minimally to steer the switches
//
// Overview of operation
// - Over-current on a driven switch sets its flag and turns it off.
// - With recovery enabled the switch returns after an off delay set by duty bit.
// - With recovery disabled the switch stays off until the reset bit write clears its flag.
// - Gated switch follows its pulse input while switched on.
// - Outputs nine and ten use input b, all others input a.
// - Supply over or under voltage sets bit 22 or 21 and turns outputs off.
// - Outputs return by themselves once the supply is normal again.
// - Thermal shutdown sets bit 20 and turns every output off.
// - Outputs stay off until the reset bit write clears thermal flag.
// - Temperature warning reported in bit 19, never switches outputs.
// - Standby to active sets not-ready bit 18 and holds outputs while settling.
// - Not-ready clears itself when the internal settling timer expires.
// - Open-load flag set after load current stays low at least 1 ms.
// - Open-load flags sit in bits 17 to 1 in switch order.
// - Bit 0 is the NOR of bits 1 to 22 of both status words.
// - Enable bit 23 selects active mode; clearing it clears both registers and all flags, not the serial frame state; reset starts standby.
// - Status bit 23 always reads one.
// - High and low switch of one half bridge are never on together.
`timescale 1ns/1ps
module rpdr_top #(
	parameter int unsigned P_TICK_CYCLES = rpdr_pkg::TICK_CYCLES
) (
	input  wire logic        i_mclk,
	input  wire logic        i_resetn,
	input  wire logic        i_spi_csn,
	input  wire logic        i_spi_sck,
	input  wire logic        i_spi_sdi,
	output logic             o_spi_sdo,
	output logic             o_spi_sdo_oe,
	input  wire logic        i_pulse_gate_input_a,
	input  wire logic        i_pulse_gate_input_b,
	input  wire logic        i_load_supply_over,
	input  wire logic        i_load_supply_under,
	input  wire logic        i_thermal_shutdown,
	input  wire logic        i_temp_warning,
	input  wire logic [16:0] i_over_current,
	input  wire logic [16:0] i_low_current,
	output logic      [16:0] o_switch_on
);

	////////////////////////////////////////////////////////////////////////////////
	// Reset release
	logic rst_meta_r;
	logic rst_sync_r;

	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end
		else
		begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisation
	rpdr_pkg::rpdr_pins_t pins_raw;
	rpdr_pkg::rpdr_pins_t p;
	logic [rpdr_pkg::PINS_W-1:0] pins_sync;

	assign pins_raw = '{
		csn:       i_spi_csn,
		sck:       i_spi_sck,
		sdi:       i_spi_sdi,
		gate_a:    i_pulse_gate_input_a,
		gate_b:    i_pulse_gate_input_b,
		sup_over:  i_load_supply_over,
		sup_under: i_load_supply_under,
		thermal_shutdown_flag:       i_thermal_shutdown,
		tw:        i_temp_warning,
		oc:        i_over_current,
		low:       i_low_current
	};

	rpdr_sync #(
		.WIDTH (rpdr_pkg::PINS_W)
	) u_sync (
		.i_mclk  (i_mclk),
		.i_rst_n (rst_sync_r),
		.i_async (pins_raw),
		.o_sync  (pins_sync)
	);

	assign p = rpdr_pkg::rpdr_pins_t'(pins_sync);

	////////////////////////////////////////////////////////////////////////////////
	// State and status words
	rpdr_pkg::rpdr_state_t r;
	rpdr_pkg::rpdr_state_t nxt;
	logic                  noerr;
	logic [23:0]           stat0;
	logic [23:0]           stat1;

	assign noerr = ~|{r.oc_flag, r.ov, r.uv, r.thermal_shutdown_flag, r.tw, r.not_ready, r.ol_flag};
	assign stat0 = {1'b1, 5'h00, r.oc_flag, noerr};
	assign stat1 = {1'b1, r.ov, r.uv, r.thermal_shutdown_flag, r.tw, r.not_ready, r.ol_flag, noerr};

	////////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb
	begin
		logic        tick;
		logic        wr;
		logic        clr;
		logic        gate;
		logic        ol_set;
		logic [16:0] drv;
		logic [3:0]  off_t;
		int unsigned n;
		tick   = 1'b0;
		wr     = 1'b0;
		clr    = 1'b0;
		gate   = 1'b0;
		ol_set = 1'b0;
		drv    = '0;
		off_t  = '0;
		n      = 0;
		nxt    = r;

		// Common time base
		tick = (r.tick_cnt == 16'(P_TICK_CYCLES - 1));
		nxt.tick_cnt = tick ? 16'h0000 : r.tick_cnt + 16'h0001;

		// Serial frame engine
		nxt.csn_d = p.csn;
		nxt.sck_d = p.sck;
		if (r.csn_d && !p.csn)
		begin
			nxt.bit_cnt = '0;
			nxt.sh_out = r.addr_prev ? stat1 : stat0;
			nxt.sdo    = r.addr_prev ? stat1[23] : stat0[23];
			nxt.sdo_oe = 1'b1;
		end
		else if (!p.csn)
		begin
			if (!r.sck_d && p.sck)
			begin
				nxt.sh_in = {r.sh_in[22:0], p.sdi};
				if (r.bit_cnt != rpdr_pkg::BIT_CNT_MAX)
					nxt.bit_cnt = r.bit_cnt + 5'h01;
			end
			if (r.sck_d && !p.sck)
			begin
				nxt.sh_out = {r.sh_out[22:0], 1'b0};
				nxt.sdo    = r.sh_out[22];
			end
		end
		else if (!r.csn_d && p.csn)
		begin
			nxt.sdo_oe = 1'b0;
			nxt.sdo    = 1'b0;
			wr         = (r.bit_cnt == 5'(rpdr_pkg::FRAME_BITS));
		end

		// Not-ready settling
		if (r.not_ready && tick)
		begin
			if (r.settle_cnt == 4'(rpdr_pkg::SETTLE_TICKS - 1))
				nxt.not_ready = 1'b0;
			else
				nxt.settle_cnt = r.settle_cnt + 4'h1;
		end

		// Register write commit
		if (wr)
		begin
			nxt.addr_prev = r.sh_in[rpdr_pkg::BIT_ADDR];
			if (r.sh_in[rpdr_pkg::BIT_ADDR])
			begin
				nxt.ctrl1 = r.sh_in;
				if (r.sh_in[rpdr_pkg::BIT_ENABLE] && !r.ctrl1[rpdr_pkg::BIT_ENABLE])
				begin
					nxt.not_ready  = 1'b1;
					nxt.settle_cnt = 4'h0;
				end
			end
			else
			begin
				nxt.ctrl0                     = r.sh_in;
				nxt.ctrl0[rpdr_pkg::BIT_RESET] = 1'b0;
				clr                           = r.sh_in[rpdr_pkg::BIT_RESET];
			end
		end

		nxt.ov  = p.sup_over | (r.ov & ~clr);
		nxt.uv  = p.sup_under | (r.uv & ~clr);
		nxt.thermal_shutdown_flag = p.thermal_shutdown_flag | (r.thermal_shutdown_flag & ~clr);
		nxt.tw  = p.tw | (r.tw & ~clr);

		off_t = r.ctrl0[rpdr_pkg::BIT_DUTY] ? 4'(rpdr_pkg::REC_SHORT_TK) : 4'(rpdr_pkg::REC_LONG_TK);

		for (int unsigned k = 0; k < rpdr_pkg::NUM_SW; k++)
		begin
			n = rpdr_pkg::out_of_switch(k);
			if (p.oc[k] && r.sw_on[k])
			begin
				nxt.oc_flag[k] = 1'b1;
				nxt.oc_off[k]  = 1'b1;
				nxt.rec_cnt[k] = 4'h0;
			end
			else if (clr)
			begin
				nxt.oc_flag[k] = 1'b0;
				nxt.oc_off[k]  = 1'b0;
			end
			else if (r.oc_off[k] && r.ctrl1[n + rpdr_pkg::REC_BIT_OFFSET] && tick)
			begin
				if (r.rec_cnt[k] == off_t - 4'h1)
					nxt.oc_off[k] = 1'b0;
				else
					nxt.rec_cnt[k] = r.rec_cnt[k] + 4'h1;
			end

			ol_set = 1'b0;
			if (r.sw_on[k] && p.low[k])
			begin
				if (tick && r.ol_cnt[k] != 3'(rpdr_pkg::OL_TICKS))
					nxt.ol_cnt[k] = r.ol_cnt[k] + 3'h1;
				ol_set = (r.ol_cnt[k] == 3'(rpdr_pkg::OL_TICKS));
			end
			else
				nxt.ol_cnt[k] = 3'h0;
			nxt.ol_flag[k] = ol_set | (r.ol_flag[k] & ~clr);

			// input b for nine and ten
			if (r.ctrl1[n])
				gate = (n == rpdr_pkg::OUT_GATE_B_LO || n == rpdr_pkg::OUT_GATE_B_HI) ? p.gate_b : p.gate_a;
			else
				gate = 1'b1;

			drv[k] = nxt.ctrl0[k + 1] & gate & ~nxt.oc_off[k] & ~nxt.thermal_shutdown_flag
				& ~p.sup_over & ~p.sup_under & ~nxt.not_ready & nxt.ctrl1[rpdr_pkg::BIT_ENABLE];
		end

		for (int unsigned j = 0; j < rpdr_pkg::NUM_PAIRS; j++)
		begin
			if (drv[2 * j] && drv[2 * j + 1])
			begin
				drv[2 * j]     = 1'b0;
				drv[2 * j + 1] = 1'b0;
			end
		end

		if (!nxt.ctrl1[rpdr_pkg::BIT_ENABLE])
		begin
			nxt.ctrl0      = rpdr_pkg::CTRL_RESET;
			nxt.ctrl1      = rpdr_pkg::CTRL_RESET;
			nxt.oc_flag    = '0;
			nxt.oc_off     = '0;
			nxt.ol_flag    = '0;
			nxt.rec_cnt    = '0;
			nxt.ol_cnt     = '0;
			nxt.ov         = 1'b0;
			nxt.uv         = 1'b0;
			nxt.thermal_shutdown_flag        = 1'b0;
			nxt.tw         = 1'b0;
			nxt.not_ready  = 1'b0;
			nxt.settle_cnt = 4'h0;
			drv            = '0;
		end

		nxt.sw_on = drv;
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge i_mclk or negedge rst_sync_r)
	begin
		if (!rst_sync_r)
			r <= rpdr_pkg::STATE_RESET;
		else
			r <= nxt;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign o_spi_sdo    = r.sdo;
	assign o_spi_sdo_oe = r.sdo_oe;
	assign o_switch_on  = r.sw_on;

endmodule

/* src/rpdr_pkg.sv */
// Purpose: Constants and types for the recovery, pulse gating and diagnosis register pair
// Assumes: 25 MHz system clock, 24-bit serial frames, 17 output switches
// Notes:   Switch index k maps to frame bit k+1
package rpdr_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Frame and field positions
	localparam int unsigned FRAME_BITS     = 24;
	localparam int unsigned NUM_SW         = 17;
	localparam int unsigned NUM_PAIRS      = 6;
	localparam int unsigned BIT_ADDR       = 0;
	localparam int unsigned BIT_NOERR      = 0;
	localparam int unsigned BIT_ENABLE     = 23;
	localparam int unsigned BIT_RESET      = 22;
	localparam int unsigned BIT_DUTY       = 21;
	localparam int unsigned BIT_OV         = 22;
	localparam int unsigned BIT_UV         = 21;
	localparam int unsigned BIT_TSD        = 20;
	localparam int unsigned BIT_TW         = 19;
	localparam int unsigned BIT_NRDY       = 18;
	localparam int unsigned REC_BIT_OFFSET = 11;
	localparam int unsigned OUT_GATE_B_LO  = 9;
	localparam int unsigned OUT_GATE_B_HI  = 10;
	localparam int unsigned SW_SINGLE_LO   = 12;

	////////////////////////////////////////////////////////////////////////////////
	// Reset value and bit counter limit
	localparam logic [23:0] CTRL_RESET   = 24'h00_0000;
	localparam logic [4:0]  BIT_CNT_MAX  = 5'h1f;

	////////////////////////////////////////////////////////////////////////////////
	// Times and counts
	localparam int unsigned CLK_MHZ       = 25;
	localparam int unsigned TICK_US       = 250;
	localparam int unsigned TICK_CYCLES   = TICK_US * CLK_MHZ;
	localparam int unsigned OL_FILTER_US  = 1000;
	localparam int unsigned OL_TICKS      = OL_FILTER_US / TICK_US + 1;
	localparam int unsigned SETTLE_US     = 1000;
	localparam int unsigned SETTLE_TICKS  = SETTLE_US / TICK_US + 1;
	localparam int unsigned REC_LONG_US   = 2000;
	localparam int unsigned REC_SHORT_US  = 500;
	localparam int unsigned REC_LONG_TK   = REC_LONG_US / TICK_US;
	localparam int unsigned REC_SHORT_TK  = REC_SHORT_US / TICK_US;

	////////////////////////////////////////////////////////////////////////////////
	// Synchronised pins
	typedef struct packed {
		logic        csn;
		logic        sck;
		logic        sdi;
		logic        gate_a;
		logic        gate_b;
		logic        sup_over;
		logic        sup_under;
		logic        thermal_shutdown_flag;
		logic        tw;
		logic [16:0] oc;
		logic [16:0] low;
	} rpdr_pins_t;

	localparam int unsigned PINS_W = $bits(rpdr_pins_t);

	////////////////////////////////////////////////////////////////////////////////
	// Block state
	typedef struct packed {
		logic [23:0]      ctrl0;
		logic [23:0]      ctrl1;
		logic [16:0]      oc_flag;
		logic [16:0]      oc_off;
		logic [16:0]      ol_flag;
		logic [16:0]      sw_on;
		logic [16:0][3:0] rec_cnt;
		logic [16:0][2:0] ol_cnt;
		logic             ov;
		logic             uv;
		logic             thermal_shutdown_flag;
		logic             tw;
		logic             not_ready;
		logic [3:0]       settle_cnt;
		logic [15:0]      tick_cnt;
		logic             csn_d;
		logic             sck_d;
		logic             addr_prev;
		logic             sdo;
		logic             sdo_oe;
		logic [4:0]       bit_cnt;
		logic [23:0]      sh_in;
		logic [23:0]      sh_out;
	} rpdr_state_t;

	localparam rpdr_state_t STATE_RESET = '0;

	// Output channel number of switch index k
	function automatic int unsigned out_of_switch(input int unsigned k);
		if (k >= SW_SINGLE_LO)
			return k - 5;
		return k / 2 + 1;
	endfunction

endpackage

/* src/rpdr_sync.sv */
// Purpose: Three-stage input synchroniser with agreement filter
// Assumes: Inputs asynchronous to i_mclk
// Notes:   Output follows once stages two and three agree
`timescale 1ns/1ps
module rpdr_sync #(
	parameter int unsigned WIDTH = 1
) (
	input  wire logic             i_mclk,
	input  wire logic             i_rst_n,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] s1_r;
	logic [WIDTH-1:0] s2_r;
	logic [WIDTH-1:0] s3_r;
	logic [WIDTH-1:0] out_r;

	////////////////////////////////////////////////////////////////////////////////
	// Stages and filter
	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			s1_r  <= '0;
			s2_r  <= '0;
			s3_r  <= '0;
			out_r <= '0;
		end
		else
		begin
			s1_r <= i_async;
			s2_r <= s1_r;
			s3_r <= s2_r;
			for (int i = 0; i < int'(WIDTH); i++)
			begin
				if (s2_r[i] == s3_r[i])
					out_r[i] <= s3_r[i];
			end
		end
	end

	assign o_sync = out_r;

endmodule

/* testbench/rpdr_assertions.sv */
// Purpose: Port assertions for rpdr_top
// Assumes: Pins held 8 cycles are seen
// Notes:   Bound below
`timescale 1ns/1ps
module rpdr_chk (
	input wire logic        i_mclk,
	input wire logic        i_resetn,
	input wire logic        i_spi_csn,
	input wire logic        o_spi_sdo,
	input wire logic        o_spi_sdo_oe,
	input wire logic        i_load_supply_over,
	input wire logic        i_load_supply_under,
	input wire logic        i_thermal_shutdown,
	input wire logic [16:0] i_over_current,
	input wire logic [16:0] o_switch_on
);
	default clocking @(posedge i_mclk);
	endclocking
	default disable iff (!i_resetn);
	////////////////////////////////////////
	property p_bridge; (o_switch_on[11:0] & (o_switch_on[11:0] >> 1) & 12'h555) == 12'h000; endproperty
	property p_tsd; i_thermal_shutdown [*8] |-> o_switch_on == 17'h0_0000; endproperty
	property p_ov; i_load_supply_over [*8] |-> o_switch_on == 17'h0_0000; endproperty
	property p_uv; i_load_supply_under [*8] |-> o_switch_on == 17'h0_0000; endproperty
	property p_oc; (|(i_over_current & o_switch_on)) [*7] |=> !(|(i_over_current & o_switch_on)); endproperty
	property p_lead; $rose(o_spi_sdo_oe) |-> ##[0:1] o_spi_sdo; endproperty
	property p_oe; i_spi_csn [*8] |-> !o_spi_sdo_oe; endproperty
	property p_idle; !o_spi_sdo_oe && !$past(o_spi_sdo_oe) |-> !o_spi_sdo; endproperty
	a_bridge: assert property (p_bridge) else $error("bridge both on");
	a_tsd: assert property (p_tsd) else $error("on in shutdown");
	a_ov: assert property (p_ov) else $error("on in overvoltage");
	a_uv: assert property (p_uv) else $error("on in undervoltage");
	a_oc: assert property (p_oc) else $error("no cut on overload");
	a_lead: assert property (p_lead) else $error("first bit not one");
	a_oe: assert property (p_oe) else $error("drive while idle");
	a_idle: assert property (p_idle) else $error("data while idle");
endmodule

bind rpdr_top rpdr_chk u_rpdr_chk (
	.i_mclk, .i_resetn, .i_spi_csn, .o_spi_sdo, .o_spi_sdo_oe, .i_load_supply_over,
	.i_load_supply_under, .i_thermal_shutdown, .i_over_current, .o_switch_on
);

/* testbench/rpdr_host.sv */
// Purpose: Host master model for the serial pair
// Assumes: Serial clock 8 system cycles
// Notes:   Data line inverted between frames
`timescale 1ns/1ps
module rpdr_host (
	input  wire logic i_mclk,
	input  wire logic i_sdo,
	output logic      o_csn,
	output logic      o_sck,
	output logic      o_sdi
);
	initial
	begin
		o_csn = 1'b1;
		o_sck = 1'b0;
		o_sdi = 1'b0;
	end
	////////////////////////////////////////
	// frame of nb bits, sent from bit 23 down
	task automatic xfer(input logic [23:0] tx, input int nb, output logic [23:0] rx);
		@(posedge i_mclk);
		o_csn <= 1'b0;
		repeat (8) @(posedge i_mclk);
		for (int i = 23; i >= 24 - nb; i--)
		begin
			o_sdi <= tx[i];
			repeat (4) @(posedge i_mclk);
			o_sck <= 1'b1;
			repeat (3) @(posedge i_mclk);
			@(negedge i_mclk);
			rx[i] = i_sdo;
			@(posedge i_mclk);
			o_sck <= 1'b0;
		end
		repeat (4) @(posedge i_mclk);
		o_csn <= 1'b1;
		o_sdi <= ~o_sdi;
		repeat (10) @(posedge i_mclk);
	endtask
endmodule

/* testbench/rpdr_tb_top.sv */
// Purpose: Self-checking bench for rpdr_top
// Assumes: Tick shortened to 200 cycles
// Notes:   Status answers previous frame address
`timescale 1ns/1ps
module rpdr_tb_top;
	logic        mclk = 1'b0;
	logic        resetn, csn, sck, sdi, sdo, oe, pa, pb, ov, uv, thermal_shutdown_flag, tw;
	logic [16:0] oc, low, sw;
	logic [23:0] rx;
	int          miscompares = 0;
	int          check_count = 0;
	always #20 mclk = ~mclk;
	rpdr_top #(
		.P_TICK_CYCLES(200)
	) u_rpdr_top (
		.i_mclk(mclk), .i_resetn(resetn), .i_spi_csn(csn), .i_spi_sck(sck), .i_spi_sdi(sdi),
		.o_spi_sdo(sdo), .o_spi_sdo_oe(oe), .i_pulse_gate_input_a(pa), .i_pulse_gate_input_b(pb),
		.i_load_supply_over(ov), .i_load_supply_under(uv), .i_thermal_shutdown(thermal_shutdown_flag),
		.i_temp_warning(tw), .i_over_current(oc), .i_low_current(low), .o_switch_on(sw)
	);
	rpdr_host u_rpdr_host (.i_mclk(mclk), .i_sdo(sdo), .o_csn(csn), .o_sck(sck), .o_sdi(sdi));
	////////////////////////////////////////
	task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic test_done();
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic fr(input logic [23:0] tx);
		u_rpdr_host.xfer(tx, 24, rx);
	endtask
	task automatic fs(input logic [23:0] tx, input logic [23:0] e);
		fr(tx);
		chk("status", rx, e);
	endtask
	task automatic cs(input int n, input logic [23:0] e);
		cyc(n);
		chk("switch", {7'h00, sw}, e);
	endtask
	////////////////////////////////////////
	initial
	begin
		resetn = 1'b0;
		{pa, pb, ov, uv, thermal_shutdown_flag, tw} = 6'h00;
		oc = 17'h0_0000;
		low = 17'h0_0000;
		cyc(12);
		resetn <= 1'b1;
		cyc(20);
		fs(24'h00_0001, 24'h80_0001);
		fs(24'h80_0281, 24'h80_0001);
		fs(24'h80_0281, 24'h84_0000);
		pa <= 1'b1;
		pb <= 1'b1;
		fr(24'h00_A006);
		cs(1, 24'h00_0000);
		cs(700, 24'h00_5000);
		for (int g = 0; g < 4; g++)
		begin
			pa <= g[0];
			pb <= g[1];
			cs(10, {9'h000, g[1], 1'b0, g[0], 12'h000});
		end
		tw <= 1'b1;
		cs(10, 24'h00_5000);
		thermal_shutdown_flag <= 1'b1;
		cs(10, 24'h00_0000);
		thermal_shutdown_flag <= 1'b0;
		tw <= 1'b0;
		cs(10, 24'h00_0000);
		fr(24'h80_0281);
		fs(24'h80_0281, 24'h98_0000);
		fr(24'h40_A006);
		cs(10, 24'h00_5000);
		fr(24'h00_A006);
		ov <= 1'b1;
		cs(10, 24'h00_0000);
		ov <= 1'b0;
		uv <= 1'b1;
		cs(10, 24'h00_0000);
		uv <= 1'b0;
		cs(10, 24'h00_5000);
		// Short frame must be dropped
		u_rpdr_host.xfer(24'h00_0000, 23, rx);
		cs(10, 24'h00_5000);
		fs(24'h80_0281, 24'h80_0000);
		fs(24'h80_0281, 24'hE0_0000);
		fr(24'h84_0281);
		fr(24'h40_A006);
		fr(24'h00_A006);
		oc[12] <= 1'b1;
		cs(10, 24'h00_4000);
		oc[12] <= 1'b0;
		fs(24'h00_A006, 24'h80_2000);
		cs(1, 24'h00_4000);
		cs(1700, 24'h00_5000);
		// Recovery off, fault held: stays off until reset bit
		fr(24'h80_0281);
		oc[12] <= 1'b1;
		cs(1700, 24'h00_4000);
		oc[12] <= 1'b0;
		fr(24'h40_A006);
		cs(10, 24'h00_5000);
		// Short off time selected by duty bit
		fr(24'h84_0281);
		fr(24'h20_A006);
		oc[12] <= 1'b1;
		cs(10, 24'h00_4000);
		oc[12] <= 1'b0;
		cs(450, 24'h00_5000);
		fr(24'h40_A006);
		fr(24'h00_A006);
		low[12] <= 1'b1;
		fs(24'h84_0281, 24'h80_0001);
		fs(24'h84_0281, 24'h80_0001);
		cyc(1100);
		fs(24'h84_0281, 24'h80_2000);
		low[12] <= 1'b0;
		fs(24'h00_0281, 24'h80_2000);
		cs(10, 24'h00_0000);
		fs(24'h00_0281, 24'h80_0001);
		test_done();
	end
	initial
	begin
		cyc(40000);
		miscompares++;
		test_done();
	end
endmodule
